// ### rtl/sbcs_integrator.sv
// One photodiode channel converter: a saturating 16-bit integrator.
module sbcs_integrator (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clear,
	input  wire logic        enable,
	input  wire logic [7:0]  sample,
	output logic      [15:0] total
);

	// Running sum, one bit wider to see overflow.
	logic [16:0] sum_d;
	logic [15:0] total_q;

	// Next sum; a carry means the converter has hit full scale.
	always_comb begin
		sum_d = {1'b0, total_q} + {9'h000, sample};
	end

	// Clear starts a fresh period; saturation keeps the code monotonic.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			total_q <= 16'h0000;
		end else if (clear) begin
			total_q <= 16'h0000;
		end else if (enable) begin
			total_q <= sum_d[16] ? 16'hffff : sum_d[15:0];
		end
	end

	assign total = total_q;

endmodule

// ### rtl/sbcs_pkg.sv
// Shared constants, types and register map of the conversion sequencer.
package sbcs_pkg;

	// Clock rate of pclk in MHz.
	localparam int CLK_MHZ = 125;
	// Unit of the integration period field, in microseconds.
	localparam int TICK_US = 100;
	// Cycles of pclk in one period unit.
	localparam int TICK_CYCLES_DEF = TICK_US * CLK_MHZ;
	// Shortest legal single-group integration period, in microseconds.
	localparam int MIN_PERIOD_US = 2800;
	// Shortest period in units, rounded up to whole units.
	localparam logic [15:0] MIN_TICKS =
		16'((MIN_PERIOD_US + TICK_US - 1) / TICK_US);

	// Register byte offsets on the APB bus.
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] PERIOD_OFF = 8'h04;
	localparam logic [7:0] STATUS_OFF = 8'h08;
	localparam logic [7:0] RAW_X_OFF  = 8'h10;
	localparam logic [7:0] RAW_Y_OFF  = 8'h14;
	localparam logic [7:0] RAW_Z_OFF  = 8'h18;
	localparam logic [7:0] RAW_N_OFF  = 8'h1c;
	localparam logic [7:0] RAW_D_OFF  = 8'h20;
	localparam logic [7:0] RAW_C_OFF  = 8'h24;
	localparam logic [7:0] CAL_X_OFF  = 8'h30;
	localparam logic [7:0] CAL_Y_OFF  = 8'h34;
	localparam logic [7:0] CAL_Z_OFF  = 8'h38;

	// Control register field positions.
	localparam int BANK_LSB     = 0;
	localparam int ALERT_EN_BIT = 2;
	localparam int READY_BIT    = 3;

	// Reset values.
	localparam logic [15:0] PERIOD_RST = 16'h0064;

	// Photodiode channel indices.
	localparam int NUM_CH = 6;
	localparam int CH_X   = 0;
	localparam int CH_Y   = 1;
	localparam int CH_Z   = 2;
	localparam int CH_N   = 3;
	localparam int CH_D   = 4;
	localparam int CH_C   = 5;
	// Channels that belong to each photodiode group.
	localparam logic [5:0] G1_MASK = 6'h0f;
	localparam logic [5:0] G2_MASK = 6'h33;

	// Bank modes, a two-bit binary field.
	typedef enum logic [1:0] {
		BANK_G1      = 2'h0,
		BANK_G2      = 2'h1,
		BANK_BOTH    = 2'h2,
		BANK_ONESHOT = 2'h3
	} sbcs_bank_t;
	localparam sbcs_bank_t BANK_RST = BANK_ONESHOT;

	// Sequencer states, Gray coded along idle, first, second.
	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_FIRST  = 2'h1,
		ST_SECOND = 2'h3
	} sbcs_state_t;

	// One full set of channel results.
	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
		logic [15:0] near_infrared_channel;
		logic [15:0] dark;
		logic [15:0] clear;
	} sbcs_res_t;

endpackage

// ### rtl/sbcs_sequencer.sv
// Conversion sequencer for a six-channel colour sensor with APB registers.
//
// The register offsets and the APB interface to the registers were left to the implementer.
module sbcs_sequencer #(
	parameter int TICK_CYCLES = sbcs_pkg::TICK_CYCLES_DEF
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	input  wire logic [5:0][7:0]  diode_level,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	output logic                  alert_n
);

	// Assertions below all use pclk and the bus reset.
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	localparam int DIV_W = $clog2(TICK_CYCLES);

	// Pin synchroniser stages; the first is read only by the second.
	logic [5:0][7:0]      lvl_s1_q;
	logic [5:0][7:0]      lvl_s2_q;
	// Period unit divider and its one-cycle enable.
	logic [DIV_W-1:0]     div_q;
	logic                 tick_q;
	// Control and period registers written by software.
	sbcs_pkg::sbcs_bank_t bank_q;
	logic                 alert_en_q;
	logic [15:0]          period_q;
	// Sequencer state and period counter.
	sbcs_pkg::sbcs_state_t state_q;
	logic [15:0]          per_cnt_q;
	// Converter outputs, staging buffer and visible results.
	logic [5:0][15:0]     acc;
	sbcs_pkg::sbcs_res_t  stage_q;
	sbcs_pkg::sbcs_res_t  res_q;
	logic [15:0]          cal_x_q;
	logic [15:0]          cal_y_q;
	logic [15:0]          cal_z_q;
	// Groups waiting to move from staging into the results.
	logic [1:0]           pend_q;
	logic                 ready_q;
	logic                 alert_n_q;
	// APB answer flops.
	logic [31:0]          prdata_q;
	logic                 pready_q;
	logic                 pslverr_q;

	// Decoded bus and sequencer events.
	logic                 setup;
	logic                 access;
	logic                 wr_ctrl;
	logic                 rd_ctrl;
	logic                 rd_result;
	logic                 result_addr;
	logic                 hold;
	logic                 restart;
	logic                 period_end;
	logic                 commit;
	logic [15:0]          eff_period;
	logic [5:0]           ch_en;
	logic                 mapped;
	logic [31:0]          rd_mux;

	// Dark-corrected value, floored at zero rather than wrapping.
	function automatic logic [15:0] dark_sub(input logic [15:0] v,
		input logic [15:0] d);
		dark_sub = (v > d) ? (v - d) : 16'h0000;
	endfunction

	// Two-flop synchroniser for the photodiode level pins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl_s1_q <= '0;
			lvl_s2_q <= '0;
		end else begin
			lvl_s1_q <= diode_level;
			lvl_s2_q <= lvl_s1_q;
		end
	end

	// Divider makes one enable pulse per period unit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (div_q == DIV_W'(TICK_CYCLES - 1)) begin
			div_q  <= '0;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	// Bus phases; writes and read side effects act at the access edge.
	always_comb begin
		setup       = psel && !penable;
		access      = psel && penable && pready_q;
		result_addr = (paddr >= sbcs_pkg::RAW_X_OFF) &&
			(paddr <= sbcs_pkg::CAL_Z_OFF) && mapped;
		wr_ctrl     = access && pwrite && (paddr == sbcs_pkg::CTRL_OFF);
		rd_ctrl     = access && !pwrite && (paddr == sbcs_pkg::CTRL_OFF);
		rd_result   = access && !pwrite && result_addr;
		// A result read in flight freezes the visible results.
		hold        = psel && !pwrite && result_addr;
	end

	// Too-short settings run at the shortest legal period instead.
	always_comb begin
		eff_period = (period_q < sbcs_pkg::MIN_TICKS) ?
			sbcs_pkg::MIN_TICKS : period_q;
		// The end falls one cycle after the last unit's tick, so that tick's
		// sample is still inside the totals that staging catches.
		period_end = (state_q != sbcs_pkg::ST_IDLE) &&
			(per_cnt_q >= eff_period);
		restart    = wr_ctrl;
		commit     = (pend_q != 2'h0) && !hold;
	end

	// Control register: bank field and alert enable.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bank_q     <= sbcs_pkg::BANK_RST;
			alert_en_q <= 1'b0;
		end else if (wr_ctrl) begin
			// Every two-bit value is a legal mode.
			bank_q     <= sbcs_pkg::sbcs_bank_t'(pwdata[1:0]);
			alert_en_q <= pwdata[sbcs_pkg::ALERT_EN_BIT];
		end
	end

	// Integration period register, in period units.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_q <= sbcs_pkg::PERIOD_RST;
		end else if (access && pwrite && (paddr == sbcs_pkg::PERIOD_OFF)) begin
			period_q <= pwdata[15:0];
		end
	end

	// Group sequence. Writing control restarts from a clean period, so
	// a one-shot write always yields two fresh periods.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= sbcs_pkg::ST_IDLE;
		end else if (restart) begin
			if (pwdata[1:0] == sbcs_pkg::BANK_G2) begin
				state_q <= sbcs_pkg::ST_SECOND;
			end else begin
				state_q <= sbcs_pkg::ST_FIRST;
			end
		end else if (period_end) begin
			unique case (state_q)
				sbcs_pkg::ST_FIRST: begin
					// Mode zero repeats group one; others go on to two.
					if (bank_q == sbcs_pkg::BANK_G1) begin
						state_q <= sbcs_pkg::ST_FIRST;
					end else begin
						state_q <= sbcs_pkg::ST_SECOND;
					end
				end
				sbcs_pkg::ST_SECOND: begin
					if (bank_q == sbcs_pkg::BANK_ONESHOT) begin
						state_q <= sbcs_pkg::ST_IDLE;
					end else if (bank_q == sbcs_pkg::BANK_G2) begin
						state_q <= sbcs_pkg::ST_SECOND;
					end else begin
						state_q <= sbcs_pkg::ST_FIRST;
					end
				end
				default: begin
					// Idle never reaches here since period_end needs a group.
					state_q <= sbcs_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Period counter in units; cleared at each group boundary.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_cnt_q <= 16'h0000;
		end else if (restart || period_end) begin
			per_cnt_q <= 16'h0000;
		end else if (tick_q && (state_q != sbcs_pkg::ST_IDLE)) begin
			per_cnt_q <= per_cnt_q + 16'h0001;
		end
	end

	// Each channel integrates while its group is being converted.
	always_comb begin
		ch_en = 6'h00;
		if (state_q == sbcs_pkg::ST_FIRST) begin
			ch_en = sbcs_pkg::G1_MASK;
		end else if (state_q == sbcs_pkg::ST_SECOND) begin
			ch_en = sbcs_pkg::G2_MASK;
		end
	end

	// One converter per photodiode channel.
	for (genvar ch = 0; ch < sbcs_pkg::NUM_CH; ch++) begin : g_ch
		sbcs_integrator u_int (
			.pclk    (pclk),
			.presetn (presetn),
			.clear   (restart || period_end),
			.enable  (tick_q && ch_en[ch]),
			.sample  (lvl_s2_q[ch]),
			.total   (acc[ch])
		);
	end

	// First buffer stage: catch a group's totals at its period end.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_q <= '0;
		end else if (period_end && (state_q == sbcs_pkg::ST_FIRST)) begin
			stage_q.x   <= acc[sbcs_pkg::CH_X];
			stage_q.y   <= acc[sbcs_pkg::CH_Y];
			stage_q.z   <= acc[sbcs_pkg::CH_Z];
			stage_q.near_infrared_channel <= acc[sbcs_pkg::CH_N];
		end else if (period_end && (state_q == sbcs_pkg::ST_SECOND)) begin
			stage_q.x     <= acc[sbcs_pkg::CH_X];
			stage_q.y     <= acc[sbcs_pkg::CH_Y];
			stage_q.dark  <= acc[sbcs_pkg::CH_D];
			stage_q.clear <= acc[sbcs_pkg::CH_C];
		end
	end

	// Pending groups: bit 0 group one fields, bit 1 group two fields.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= 2'h0;
		end else if (restart) begin
			pend_q <= 2'h0;
		end else if (period_end && (state_q == sbcs_pkg::ST_FIRST) &&
			(bank_q == sbcs_pkg::BANK_G1)) begin
			pend_q <= 2'h1;
		end else if (period_end && (state_q == sbcs_pkg::ST_SECOND)) begin
			// Modes two and three publish all six after the pair.
			pend_q <= (bank_q == sbcs_pkg::BANK_G2) ? 2'h2 : 2'h3;
		end else if (commit) begin
			pend_q <= 2'h0;
		end
	end

	// Second buffer stage: visible results, only the pending fields move.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_q <= '0;
		end else if (commit) begin
			if (pend_q[0]) begin
				res_q.x   <= stage_q.x;
				res_q.y   <= stage_q.y;
				res_q.z   <= stage_q.z;
				res_q.near_infrared_channel <= stage_q.near_infrared_channel;
			end
			if (pend_q[1]) begin
				res_q.x     <= stage_q.x;
				res_q.y     <= stage_q.y;
				res_q.dark  <= stage_q.dark;
				res_q.clear <= stage_q.clear;
			end
		end
	end

	// Corrected colour values exist only when both groups were converted.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_x_q <= 16'h0000;
			cal_y_q <= 16'h0000;
			cal_z_q <= 16'h0000;
		end else if (commit && (pend_q == 2'h3)) begin
			cal_x_q <= dark_sub(stage_q.x, stage_q.dark);
			cal_y_q <= dark_sub(stage_q.y, stage_q.dark);
			cal_z_q <= dark_sub(stage_q.z, stage_q.dark);
		end
	end

	// Ready flag; a new result wins over a same-cycle clearing read.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q <= 1'b0;
		end else if (commit) begin
			ready_q <= 1'b1;
		end else if (rd_result) begin
			ready_q <= 1'b0;
		end
	end

	// Alert line stays low until control is read, even across periods.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alert_n_q <= 1'b1;
		end else if (commit && alert_en_q) begin
			alert_n_q <= 1'b0;
		end else if (rd_ctrl) begin
			alert_n_q <= 1'b1;
		end
	end

	// Register read multiplexer; unmapped offsets read zero with error.
	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			sbcs_pkg::CTRL_OFF: begin
				rd_mux[1:0] = bank_q;
				rd_mux[sbcs_pkg::ALERT_EN_BIT] = alert_en_q;
				rd_mux[sbcs_pkg::READY_BIT] = ready_q;
			end
			sbcs_pkg::PERIOD_OFF: rd_mux[15:0] = period_q;
			sbcs_pkg::STATUS_OFF: rd_mux[3:0] = {pend_q, state_q};
			sbcs_pkg::RAW_X_OFF:  rd_mux[15:0] = res_q.x;
			sbcs_pkg::RAW_Y_OFF:  rd_mux[15:0] = res_q.y;
			sbcs_pkg::RAW_Z_OFF:  rd_mux[15:0] = res_q.z;
			sbcs_pkg::RAW_N_OFF:  rd_mux[15:0] = res_q.near_infrared_channel;
			sbcs_pkg::RAW_D_OFF:  rd_mux[15:0] = res_q.dark;
			sbcs_pkg::RAW_C_OFF:  rd_mux[15:0] = res_q.clear;
			sbcs_pkg::CAL_X_OFF:  rd_mux[15:0] = cal_x_q;
			sbcs_pkg::CAL_Y_OFF:  rd_mux[15:0] = cal_y_q;
			sbcs_pkg::CAL_Z_OFF:  rd_mux[15:0] = cal_z_q;
			default: mapped = 1'b0;
		endcase
	end

	// APB answer: data captured in setup, ready in the first access cycle.
	// Capturing early keeps every output on a flop at no wait-state cost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup && !mapped;
			if (setup && !pwrite) begin
				prdata_q <= rd_mux;
			end
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign alert_n = alert_n_q;

	chk_alert_on_commit: assert property (
		commit && alert_en_q |=> !alert_n
	) else $error("alert not driven low on new data");

	chk_ready_on_commit: assert property (
		commit |=> ready_q && pend_q == 2'h0
	) else $error("ready flag not set after result transfer");

	chk_read_clears: assert property (
		rd_result && !commit |=> !ready_q
	) else $error("result read did not clear ready");

	chk_hold_update: assert property (
		hold |=> $stable(res_q)
	) else $error("results changed during a result access");

	chk_mode0_only: assert property (
		commit && pend_q == 2'h1 |=> $stable(res_q.dark) && $stable(res_q.clear)
	) else $error("mode zero touched group two results");

	chk_mode1_only: assert property (
		commit && pend_q == 2'h2 |=> $stable(res_q.z) && $stable(res_q.near_infrared_channel)
	) else $error("mode one touched group one results");

	chk_oneshot_stop: assert property (
		period_end && state_q == sbcs_pkg::ST_SECOND && !restart &&
		bank_q == sbcs_pkg::BANK_ONESHOT |=> state_q == sbcs_pkg::ST_IDLE
	) else $error("one-shot did not stop after two periods");

	chk_pair_order: assert property (
		period_end && state_q == sbcs_pkg::ST_FIRST && !restart &&
		bank_q != sbcs_pkg::BANK_G1 |=> state_q == sbcs_pkg::ST_SECOND
	) else $error("second group did not follow the first");

	chk_min_period: assert property (
		period_end |-> per_cnt_q >= sbcs_pkg::MIN_TICKS
	) else $error("period shorter than the legal minimum");

endmodule

// ### testbench/sbcs_light.sv
// Light source model that drives the six photodiode levels of the sensor.
module sbcs_light (
	input  wire logic [1:0]      scene,
	output logic      [5:0][7:0] level
);
	timeunit 1ns;
	timeprecision 1ps;

	// Each scene holds a steady level per channel, changed only by the bench.
	// Dark sits below X so that the corrected value stays above zero.
	always_comb begin
		for (int ch = 0; ch < 6; ch++) begin
			level[ch] = 8'(20 * int'(scene) + 30 - 5 * ch);
		end
	end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the conversion sequencer driven over APB.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TC = 4;       // Cycles per unit, shortened for speed.
	localparam int P  = 28 * TC; // Shortest integration period in cycles.

	logic            pclk;        // Bus clock.
	logic            presetn;     // Active-low reset.
	logic            psel;        // APB select.
	logic            penable;     // APB access phase.
	logic            pwrite;      // APB direction.
	logic [7:0]      paddr;       // APB byte address.
	logic [31:0]     pwdata;      // APB write data.
	logic [5:0][7:0] diode_level; // Photodiode levels from the light model.
	logic [31:0]     prdata;      // APB read data.
	logic            pready;      // APB ready.
	logic            pslverr;     // APB error.
	logic            alert_n;     // Active-low data-ready alert.
	logic [1:0]      scene;       // Light scene chosen by the bench.
	logic [31:0]     rd;          // Last read data.
	logic            rd_err;      // Last error response.
	int              err_count;   // Mismatches seen.
	int              n_checks;    // Comparisons made.

	sbcs_sequencer #(.TICK_CYCLES(TC)) u_dut (
		.pclk        (pclk),
		.presetn     (presetn),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.diode_level (diode_level),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.alert_n     (alert_n)
	);

	sbcs_light u_light (
		.scene (scene),
		.level (diode_level)
	);

	// Free-running 125 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request holds until pready is seen at an edge.
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd      = prdata;
		rd_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// A slave that never answers would hang the run, so cut it here.
		if (n >= 20) begin
			err_count++;
			$display("[ERR] %0t no bus answer", $time);
			final_report();
		end
	endtask

	// Counts edges until alert_n goes low, giving up after hi edges.
	task automatic wait_alert(input int hi, output int n);
		n = 0;
		while (alert_n !== 1'b0 && n < hi) begin
			@(posedge pclk);
			n++;
		end
	endtask

	// Expected level of one channel in one scene.
	function automatic logic [15:0] lvl(input int s, input int ch);
		return 16'(20 * s + 30 - 5 * ch);
	endfunction

	// Reads the six raw results; channels in mask expect the new scene.
	task automatic read_raw(input int s_new, input int s_old,
			input logic [5:0] mask);
		for (int ch = 0; ch < 6; ch++) begin
			apb(1'b0, sbcs_pkg::RAW_X_OFF + 8'(4 * ch), 32'h0);
			chk(rd, {16'h0, 16'(28) * lvl(mask[ch] ? s_new : s_old, ch)});
		end
	endtask

	// Reset values, an unmapped address and the period setting.
	task automatic t_reset();
		chk({31'h0, alert_n}, 32'h1);
		apb(1'b0, sbcs_pkg::CTRL_OFF, 32'h0);
		chk(rd, 32'h3);
		apb(1'b0, sbcs_pkg::PERIOD_OFF, 32'h0);
		chk(rd, 32'h64);
		apb(1'b0, 8'h3c, 32'h0);
		chk({31'h0, rd_err}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, sbcs_pkg::PERIOD_OFF, 32'h1c);
		apb(1'b0, sbcs_pkg::PERIOD_OFF, 32'h0);
		chk(rd, 32'h1c);
		$display("test reset done");
	endtask

	// One-shot run: two periods, ready and alert, then it stays idle.
	task automatic t_oneshot();
		int n;
		scene <= 2'h1;
		apb(1'b1, sbcs_pkg::CTRL_OFF, 32'h7);
		wait_alert(3 * P, n);
		chk({31'h0, n >= 2 * P - 2 && n <= 2 * P + 12}, 32'h1);
		apb(1'b0, sbcs_pkg::CTRL_OFF, 32'h0);
		chk(rd, 32'hf);
		// The release lands at the access edge; look once it has settled.
		@(posedge pclk);
		chk({31'h0, alert_n}, 32'h1);
		read_raw(1, 1, 6'h3f);
		apb(1'b0, sbcs_pkg::CAL_X_OFF, 32'h0);
		chk(rd, 32'(28 * (lvl(1, 0) - lvl(1, 4))));
		apb(1'b0, sbcs_pkg::CTRL_OFF, 32'h0);
		chk(rd, 32'h7);
		// No second run may start without a new write of the control register.
		wait_alert(3 * P, n);
		chk(n, 3 * P);
		apb(1'b0, sbcs_pkg::STATUS_OFF, 32'h0);
		chk(rd & 32'h3, 32'h0);
		$display("test oneshot done");
	endtask

	// A continuous mode: first data after per cycles, then again per later.
	task automatic t_cont(input logic [1:0] bank, input int s_new,
			input int s_old, input logic [5:0] mask, input int per);
		int n;
		scene <= 2'(s_new);
		apb(1'b1, sbcs_pkg::CTRL_OFF, {29'h0, 1'b1, bank});
		wait_alert(3 * per, n);
		chk({31'h0, n >= per - 2 && n <= per + 12}, 32'h1);
		read_raw(s_new, s_old, mask);
		if (bank == 2'h2) begin
			apb(1'b0, sbcs_pkg::CAL_X_OFF, 32'h0);
			chk(rd, 32'(28 * (lvl(s_new, 0) - lvl(s_new, 4))));
		end
		// Prompt service keeps both groups from the same cycle.
		apb(1'b0, sbcs_pkg::CTRL_OFF, 32'h0);
		@(posedge pclk);
		chk({31'h0, alert_n}, 32'h1);
		wait_alert(3 * per, n);
		chk({31'h0, n <= per + 2 && n >= per - 40}, 32'h1);
		apb(1'b0, sbcs_pkg::CTRL_OFF, 32'h0);
		chk(rd & 32'h8, 32'h8);
		$display("test mode %0d done", bank);
	endtask

	// Main sequence.
	initial begin
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		scene     = 2'h1;
		err_count = 0;
		n_checks  = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_oneshot();
		t_cont(2'h0, 2, 1, 6'h0f, P);
		t_cont(2'h1, 3, 2, 6'h33, P);
		t_cont(2'h2, 1, 3, 6'h3f, 2 * P);
		final_report();
	end
endmodule
